// ==== logic/sfc_flash_ctrl.sv ====
// Purpose: serial flash code fetch with cache, plus firmware command path
// Assumes: command inputs stay stable while launch_busy is high
// Notes: fetched bytes reach the processor through a 16-word FIFO
`timescale 1ns/1ns

// small synchronous FIFO; all state lives in one packed struct
module sfc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW + 1)'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage words
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // words held
  } sfc_fifo_st_t;
  sfc_fifo_st_t st;
  sfc_fifo_st_t next_st;
  logic push;
  logic pop;

  // honest flags straight from the word count
  assign in_ready = st.cnt != FULL;
  assign out_valid = st.cnt != '0;
  assign out_data = st.mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module sfc_flash_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  // processor fetch request and answer
  input wire logic cpu_req_valid,
  input wire logic [23:0] cpu_req_addr,
  output logic cpu_req_ready,
  output logic cpu_resp_valid,
  input wire logic cpu_resp_ready,
  output logic [7:0] cpu_resp_data,
  // configuration
  input wire logic fetch_dual_sel,
  input wire logic link_30mhz_sel,
  input wire logic exec_internal,
  // command path
  input wire logic [63:0] command_byte_buffer,
  input wire logic [3:0] transfer_byte_count,
  input wire logic launch_set,
  output logic launch_busy,
  output logic [63:0] response_byte_buffer,
  // flash pins
  output logic flash_cs_n,
  output logic flash_sck,
  output logic flash_io0_out,
  output logic flash_io0_oe,
  input wire logic flash_io0_in,
  input wire logic flash_serial_in_line
);
  typedef struct packed {
    sfc_pkg::sfc_state_t state; // sequencer state
    logic cs_n; // chip select pin
    logic sck; // serial clock pin
    logic io0_out; // io0 drive value
    logic io0_oe; // io0 drive enable
    logic io0_m; // io0 synchroniser stages
    logic io0_s;
    logic io1_m; // serial input synchroniser stages
    logic io1_s;
    logic [1:0] div_cnt; // half period divider
    logic [2:0] bit_cnt; // falling edges within the byte
    logic [3:0] idx; // byte index in header or command
    logic [3:0] cmd_len; // latched transfer length
    logic [7:0] tx_sh; // outgoing byte
    logic [7:0] rx_sh; // incoming byte
    logic dual_act; // burst runs in dual mode
    logic cmd_act; // transfer is a command
    logic go; // launch bit
    logic prev_mode; // mode seen last cycle
    logic [2:0] gap; // deselect time left
    logic [23:0] last_addr; // address of last fetched byte
    logic [23:0] base; // oldest cached address
    logic [5:0] len; // cached byte count
    logic [31:0][7:0] cache; // cached bytes by address low bits
    logic [7:0][7:0] resp; // response bytes
  } sfc_st_t;
  sfc_st_t st;
  sfc_st_t nx;
  logic mode; // effective dual selection
  logic active; // serial clock running
  logic tick; // divider enable pulse
  logic byte_done; // last falling edge of a byte
  logic [2:0] bit_last; // last bit index for current byte
  logic [7:0] rx_new; // byte after this sample
  logic hit; // request address is cached
  logic seq; // request follows last address
  logic fifo_push;
  logic fifo_in_ready;
  logic [7:0] push_data;

  // header byte for a fetch: opcode, three address bytes, dummy
  function automatic logic [7:0] hdr_byte(input logic dual,
                                          input logic [23:0] addr,
                                          input logic [3:0] i);
    logic [7:0] b;
    b = sfc_pkg::SFC_DUMMY_BYTE;
    unique case (i)
      4'h0: b = dual ? sfc_pkg::SFC_DUAL_READ_OP : sfc_pkg::SFC_FAST_READ_OP;
      4'h1: b = addr[23:16];
      4'h2: b = addr[15:8];
      4'h3: b = addr[7:0];
      default: b = sfc_pkg::SFC_DUMMY_BYTE;
    endcase
    return b;
  endfunction

  // command byte, or fill once the buffer runs out
  function automatic logic [7:0] cmd_byte(input logic [63:0] buf_in,
                                          input logic [3:0] i);
    logic [7:0] b;
    b = sfc_pkg::SFC_FILL_BYTE;
    if (i < sfc_pkg::SFC_CMD_BYTES) begin
      b = buf_in[{i[2:0], 3'h0} +: 8];
    end
    return b;
  endfunction

  // cache range check against the sliding window
  function automatic logic cache_hit(input logic [23:0] addr,
                                     input logic [23:0] base,
                                     input logic [5:0] len);
    logic [23:0] off;
    off = addr - base;
    return (len != 6'h00) && (off < {18'h0, len});
  endfunction

  assign mode = fetch_dual_sel && link_30mhz_sel;
  assign active = (st.state == sfc_pkg::sfc_hdr) ||
                  (st.state == sfc_pkg::sfc_data) ||
                  (st.state == sfc_pkg::sfc_cmd);
  assign tick = active && (st.div_cnt == 2'h0);
  assign bit_last = (st.state == sfc_pkg::sfc_data && st.dual_act) ?
                    sfc_pkg::SFC_BIT_LAST_DUAL : sfc_pkg::SFC_BIT_LAST_SINGLE;
  assign hit = cache_hit(cpu_req_addr, st.base, st.len);
  assign seq = cpu_req_addr == (st.last_addr + 24'h000001);

  // pins and status come straight from the state register
  assign flash_cs_n = st.cs_n;
  assign flash_sck = st.sck;
  assign flash_io0_out = st.io0_out;
  assign flash_io0_oe = st.io0_oe;
  assign launch_busy = st.go;
  assign response_byte_buffer = st.resp;

  // answer FIFO; a full FIFO holds back request acceptance
  sfc_fifo #(
    .W(sfc_pkg::SFC_BYTE_W),
    .D(sfc_pkg::SFC_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(cpu_resp_valid),
    .out_ready(cpu_resp_ready),
    .out_data(cpu_resp_data)
  );

  // sequencer: divider, shifter, fetch, cache and command path
  always_comb begin
    nx = st;
    fifo_push = 1'b0;
    push_data = 8'h00;
    cpu_req_ready = 1'b0;
    byte_done = 1'b0;
    rx_new = st.rx_sh;
    // two flops on every pin input
    nx.io0_m = flash_io0_in;
    nx.io0_s = st.io0_m;
    nx.io1_m = flash_serial_in_line;
    nx.io1_s = st.io1_m;
    nx.go = st.go | launch_set;
    // divider only runs while a byte is on the wire
    if (active) begin
      if (st.div_cnt == 2'h0) begin
        nx.div_cnt = st.dual_act ? sfc_pkg::SFC_DIV_DUAL
                                 : sfc_pkg::SFC_DIV_NORM;
      end else begin
        nx.div_cnt = st.div_cnt - 2'h1;
      end
    end
    // rising edge only raises sck; sampling waits for the falling edge
    // so the synchroniser delay stays inside the data valid window
    if (tick) begin
      if (!st.sck) begin
        nx.sck = 1'b1;
      end else begin
        nx.sck = 1'b0;
        if (st.state == sfc_pkg::sfc_data && st.dual_act) begin
          rx_new = {st.rx_sh[5:0], st.io1_s, st.io0_s};
        end else begin
          rx_new = {st.rx_sh[6:0], st.io1_s};
        end
        nx.rx_sh = rx_new;
        if (st.bit_cnt == bit_last) begin
          byte_done = 1'b1;
          nx.bit_cnt = 3'h0;
        end else begin
          nx.bit_cnt = st.bit_cnt + 3'h1;
          nx.tx_sh = {st.tx_sh[6:0], 1'b0};
          nx.io0_out = st.tx_sh[6];
        end
      end
    end
    unique case (st.state)
      sfc_pkg::sfc_idle: begin
        if (st.gap != 3'h0) begin
          nx.gap = st.gap - 3'h1;
        end
        if (st.go && st.gap == 3'h0) begin
          if (transfer_byte_count == 4'h0) begin
            nx.go = launch_set; // nothing to send
          end else begin
            nx.state = sfc_pkg::sfc_cmd;
            nx.cs_n = 1'b0;
            nx.cmd_act = 1'b1;
            nx.dual_act = 1'b0;
            nx.idx = 4'h0;
            nx.cmd_len = transfer_byte_count;
            nx.tx_sh = cmd_byte(command_byte_buffer, 4'h0);
            nx.io0_out = command_byte_buffer[7];
            nx.io0_oe = 1'b1;
            nx.bit_cnt = 3'h0;
            nx.div_cnt = sfc_pkg::SFC_DIV_NORM;
            nx.resp = '0;
          end
        end else if (cpu_req_valid && !exec_internal && fifo_in_ready) begin
          if (hit) begin
            cpu_req_ready = 1'b1;
            fifo_push = 1'b1;
            push_data = st.cache[cpu_req_addr[4:0]];
          end else if (st.gap == 3'h0) begin
            cpu_req_ready = 1'b1;
            nx.state = sfc_pkg::sfc_hdr;
            nx.cs_n = 1'b0;
            nx.cmd_act = 1'b0;
            nx.dual_act = mode;
            nx.idx = 4'h0;
            nx.last_addr = cpu_req_addr;
            nx.base = cpu_req_addr;
            nx.len = 6'h00;
            nx.tx_sh = hdr_byte(mode, cpu_req_addr, 4'h0);
            nx.io0_out = nx.tx_sh[7];
            nx.io0_oe = 1'b1;
            nx.bit_cnt = 3'h0;
            nx.div_cnt = mode ? sfc_pkg::SFC_DIV_DUAL : sfc_pkg::SFC_DIV_NORM;
          end
        end
      end
      sfc_pkg::sfc_hdr: begin
        if (byte_done) begin
          if (st.idx == sfc_pkg::SFC_HDR_LAST) begin
            nx.state = sfc_pkg::sfc_data;
            nx.io0_oe = !st.dual_act; // in dual mode the flash drives both lines; single keeps io0 driven
          end else begin
            nx.idx = st.idx + 4'h1;
            nx.tx_sh = hdr_byte(st.dual_act, st.last_addr, nx.idx);
            nx.io0_out = nx.tx_sh[7];
          end
        end
      end
      sfc_pkg::sfc_data: begin
        if (byte_done) begin
          fifo_push = 1'b1;
          push_data = rx_new;
          nx.cache[st.last_addr[4:0]] = rx_new;
          if (st.len == sfc_pkg::SFC_CACHE_BYTES) begin
            nx.base = st.base + 24'h000001;
          end else begin
            nx.len = st.len + 6'h01;
          end
          nx.state = sfc_pkg::sfc_hold;
        end
      end
      sfc_pkg::sfc_hold: begin
        // burst stays open with sck low until the next address shows
        if (st.go || exec_internal) begin
          nx.state = sfc_pkg::sfc_end;
        end else if (cpu_req_valid) begin
          if (seq) begin
            if (fifo_in_ready) begin
              cpu_req_ready = 1'b1;
              nx.state = sfc_pkg::sfc_data;
              nx.last_addr = cpu_req_addr;
              nx.bit_cnt = 3'h0;
              nx.div_cnt = st.dual_act ? sfc_pkg::SFC_DIV_DUAL
                                       : sfc_pkg::SFC_DIV_NORM;
            end
          end else if (hit) begin
            if (fifo_in_ready) begin
              cpu_req_ready = 1'b1;
              fifo_push = 1'b1;
              push_data = st.cache[cpu_req_addr[4:0]];
              nx.state = sfc_pkg::sfc_end;
            end
          end else begin
            nx.state = sfc_pkg::sfc_end;
          end
        end
      end
      sfc_pkg::sfc_cmd: begin
        if (byte_done) begin
          // the opcode slot hears nothing; later bytes are answers
          if (st.idx != 4'h0 && st.idx <= sfc_pkg::SFC_CMD_BYTES) begin
            nx.resp[3'(st.idx - 4'h1)] = rx_new;
          end
          if (4'(st.idx + 4'h1) == st.cmd_len) begin
            nx.state = sfc_pkg::sfc_end;
          end else begin
            nx.idx = st.idx + 4'h1;
            nx.tx_sh = cmd_byte(command_byte_buffer, nx.idx);
            nx.io0_out = nx.tx_sh[7];
          end
        end
      end
      sfc_pkg::sfc_end: begin
        nx.cs_n = 1'b1;
        nx.io0_oe = 1'b0;
        nx.state = sfc_pkg::sfc_rel;
      end
      sfc_pkg::sfc_rel: begin
        if (st.cmd_act) begin
          nx.go = launch_set; // new launch wins over the clear
        end
        nx.cmd_act = 1'b0;
        nx.gap = sfc_pkg::SFC_GAP_LOAD;
        nx.state = sfc_pkg::sfc_idle;
      end
    endcase
    // a mode change makes every cached byte suspect
    if (mode != st.prev_mode) begin
      nx.len = 6'h00;
      nx.prev_mode = mode;
    end
  end

  // state register; reset leaves the cache empty and select high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.cs_n <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // helper for checks: serial clock rises within a command
  logic [7:0] a_rise_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      a_rise_cnt <= 8'h00;
    end else if (st.state == sfc_pkg::sfc_idle) begin
      a_rise_cnt <= 8'h00;
    end else if (st.cmd_act && tick && !st.sck) begin
      a_rise_cnt <= a_rise_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_hdr_start;
    st.state == sfc_pkg::sfc_idle ##1 st.state == sfc_pkg::sfc_hdr;
  endsequence
  sequence s_hold_jump;
    st.state == sfc_pkg::sfc_hold && cpu_req_valid && !seq && !hit &&
      !st.go && !exec_internal;
  endsequence
  sequence s_cmd_release;
    st.state == sfc_pkg::sfc_end && st.cmd_act ##1 st.cs_n;
  endsequence

  a_fast_read_op:
    assert property (s_hdr_start ##0 !st.dual_act |->
      st.tx_sh == sfc_pkg::SFC_FAST_READ_OP && !st.cs_n)
    else $error("single fetch did not open with fast read");
  a_dual_read_op:
    assert property (s_hdr_start ##0 st.dual_act |->
      st.tx_sh == sfc_pkg::SFC_DUAL_READ_OP && !st.cs_n)
    else $error("dual fetch did not open with dual read");
  a_dual_needs_30:
    assert property (s_hdr_start ##0 st.dual_act |-> $past(link_30mhz_sel))
    else $error("dual fetch started without 30 MHz link");
  a_jump_base:
    assert property (s_hdr_start |->
      st.base == st.last_addr && st.len == 6'h00)
    else $error("cache base not loaded on jump");
  a_cache_len:
    assert property (st.len <= sfc_pkg::SFC_CACHE_BYTES)
    else $error("cache length past 32");
  a_byte_ready:
    assert property (st.state == sfc_pkg::sfc_data && byte_done |=>
      cpu_resp_valid && st.state == sfc_pkg::sfc_hold)
    else $error("fetched byte not offered");
  a_seq_keeps:
    assert property (st.state == sfc_pkg::sfc_hold && cpu_req_ready && seq
      |=> st.state == sfc_pkg::sfc_data && !st.cs_n)
    else $error("sequential fetch closed the burst");
  a_jump_closes:
    assert property (s_hold_jump |-> ##2 st.cs_n)
    else $error("jump did not raise chip select");
  a_hit_one_clk:
    assert property (st.state == sfc_pkg::sfc_idle && cpu_req_ready && hit
      |=> cpu_resp_valid && st.cs_n)
    else $error("cache hit not answered next clock");
  a_dual_four:
    assert property (st.state == sfc_pkg::sfc_data && st.dual_act |->
      st.bit_cnt <= sfc_pkg::SFC_BIT_LAST_DUAL)
    else $error("dual byte ran past four clocks");
  a_cmd_clocks:
    assert property (st.state == sfc_pkg::sfc_end && st.cmd_act |->
      a_rise_cnt == {1'b0, st.cmd_len, 3'h0})
    else $error("command clock count wrong");
  a_go_clears:
    assert property (s_cmd_release |=> !st.go || $past(launch_set))
    else $error("launch bit did not clear");
  a_idle_select:
    assert property (st.state == sfc_pkg::sfc_idle |-> st.cs_n)
    else $error("chip select low while idle");
endmodule

// ==== logic/sfc_pkg.sv ====
// Purpose: constants and types of the serial flash fetch and command block
// Assumes: core clock of 125 MHz, flash in serial mode 0
// Notes: opcodes are the ones firmware and the fetch engine place on io0
package sfc_pkg;
  // core clock
  localparam int SFC_CLK_MHZ = 125;
  localparam int SFC_CLK_NS = 8;
  // chip select high time between transfers, rounded up to whole cycles
  localparam int SFC_CEH_NS = 50;
  localparam int SFC_CEH_CYC = (SFC_CEH_NS + SFC_CLK_NS - 1) / SFC_CLK_NS;
  localparam logic [2:0] SFC_GAP_LOAD = 3'(SFC_CEH_CYC - 1);
  // link rates; dual mode needs the 30 MHz divider
  localparam int SFC_SCK_MHZ = 20;
  localparam int SFC_DUAL_SCK_MHZ = 30;
  localparam int SFC_HALF_NORM = SFC_CLK_MHZ / (2 * SFC_SCK_MHZ);
  localparam int SFC_HALF_DUAL = SFC_CLK_MHZ / (2 * SFC_DUAL_SCK_MHZ);
  localparam logic [1:0] SFC_DIV_NORM = 2'(SFC_HALF_NORM - 1);
  localparam logic [1:0] SFC_DIV_DUAL = 2'(SFC_HALF_DUAL - 1);
  // opcodes
  localparam logic [7:0] SFC_FAST_READ_OP = 8'h0b;
  localparam logic [7:0] SFC_DUAL_READ_OP = 8'h3b;
  localparam logic [7:0] SFC_SECTOR_ERASE_OP = 8'h20;
  localparam logic [7:0] SFC_BLOCK32_ERASE_OP = 8'h52;
  localparam logic [7:0] SFC_BLOCK64_ERASE_OP = 8'hd8;
  localparam logic [7:0] SFC_BYTE_PROGRAM_OP = 8'h02;
  localparam logic [7:0] SFC_ID_READ_OP = 8'h9f;
  // byte counts firmware loads for the standard commands
  localparam logic [3:0] SFC_ERASE_LEN = 4'h4;
  localparam logic [3:0] SFC_PROGRAM_LEN = 4'h5;
  localparam logic [3:0] SFC_OPCODE_LEN = 4'h1;
  localparam logic [3:0] SFC_ID_LEN = 4'h4;
  // fill values for dummy and don't-care bytes
  localparam logic [7:0] SFC_DUMMY_BYTE = 8'h00;
  localparam logic [7:0] SFC_FILL_BYTE = 8'h00;
  // structure sizes
  localparam int SFC_ADDR_W = 24;
  localparam int SFC_BYTE_W = 8;
  localparam int SFC_FIFO_DEPTH = 16;
  localparam logic [5:0] SFC_CACHE_BYTES = 6'h20;
  localparam logic [3:0] SFC_CMD_BYTES = 4'h8;
  localparam logic [3:0] SFC_HDR_LAST = 4'h4;
  localparam logic [2:0] SFC_BIT_LAST_SINGLE = 3'h7;
  localparam logic [2:0] SFC_BIT_LAST_DUAL = 3'h3;
  // sequencer states
  typedef enum logic [2:0] {
    sfc_idle, sfc_hdr, sfc_data, sfc_hold, sfc_cmd, sfc_end, sfc_rel
  } sfc_state_t;
endpackage

// ==== tb/sfc_flash_model.sv ====
// Purpose: behavioural serial flash at the far side of the fetch block
// Assumes: mode 0, takes io0 on rising sck, drives on falling sck
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ns
module sfc_flash_model #(
  parameter logic [23:0] ID_CODE = 24'h123456 // arbitrary value
) (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic io0,
  output logic io0_drv,
  output logic io1
);
  logic [7:0] rx_log [0:15]; // bytes taken in this frame
  logic [7:0] sh; // incoming shift register
  logic [7:0] d; // byte being sent
  int nbits = 0; // rising clocks seen in this frame
  int k;
  // contents are a fixed pattern of the address
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  initial io0_drv = 1'b0;
  initial io1 = 1'b0;
  // a new frame restarts the bit count
  always @(negedge cs_n) nbits = 0;
  // deselect releases the output line
  always @(posedge cs_n) io1 = ~io1;
  // take host bits; opcode, address and data land in the log
  always @(posedge sck) begin
    sh = {sh[6:0], io0};
    nbits = nbits + 1;
    if (nbits % 8 == 0 && nbits <= 128) rx_log[nbits / 8 - 1] = sh;
  end
  // answer on the falling edge so data is settled for the next rise
  always @(negedge sck) begin
    k = nbits - 40;
    if (rx_log[0] === 8'h0b && k >= 0) begin
      d = mem({rx_log[1], rx_log[2], rx_log[3]} + 24'(k / 8));
      io1 = d[7 - k % 8];
    end else if (rx_log[0] === 8'h3b && k >= 0) begin
      d = mem({rx_log[1], rx_log[2], rx_log[3]} + 24'(k / 4));
      io1 = d[7 - 2 * (k % 4)];
      io0_drv = d[6 - 2 * (k % 4)];
    end else if (rx_log[0] === 8'h9f && nbits >= 8 && nbits < 32) begin
      io1 = ID_CODE[31 - nbits];
    end else begin
      io1 = ~io1; // not driven by the flash
      io0_drv = ~io0_drv;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the flash fetch and command block
// Assumes: inputs change on the falling clock edge
// Notes: flash contents come from a fixed address pattern
`timescale 1ns/1ns
module tb_top;
  localparam logic [23:0] ID = 24'h123456; // arbitrary value
  localparam logic [7:0] WEN_OP = 8'h06; // firmware-chosen opcode
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [23:0] req_addr = 24'h0;
  logic resp_ready = 1'b0;
  logic dual = 1'b0;
  logic l30 = 1'b0;
  logic exec_int = 1'b0;
  logic [63:0] cmd_buf = 64'h0;
  logic [3:0] cnt = 4'h0;
  logic launch = 1'b0;
  logic req_ready, resp_valid, busy, cs_n, sck, io0o, io0oe, io0d, io1;
  logic [7:0] resp_data;
  logic [63:0] resp_buf;
  wire io0_pin = io0oe ? io0o : io0d; // shared io0 wire
  int fails = 0;
  int n_checks = 0;
  int n_cs = 0; // chip select falls
  always @(negedge cs_n) n_cs++;
  initial forever #4 core_clk = ~core_clk;
  sfc_flash_ctrl uut (.core_clk(core_clk), .rst(rst),
    .cpu_req_valid(req_valid), .cpu_req_addr(req_addr),
    .cpu_req_ready(req_ready), .cpu_resp_valid(resp_valid),
    .cpu_resp_ready(resp_ready), .cpu_resp_data(resp_data),
    .fetch_dual_sel(dual), .link_30mhz_sel(l30), .exec_internal(exec_int),
    .command_byte_buffer(cmd_buf), .transfer_byte_count(cnt),
    .launch_set(launch), .launch_busy(busy), .response_byte_buffer(resp_buf),
    .flash_cs_n(cs_n), .flash_sck(sck), .flash_io0_out(io0o),
    .flash_io0_oe(io0oe), .flash_io0_in(io0_pin),
    .flash_serial_in_line(io1));
  sfc_flash_model #(.ID_CODE(ID)) fl (.cs_n(cs_n), .sck(sck), .io0(io0_pin),
    .io0_drv(io0d), .io1(io1));
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic check(input string nm, input logic [63:0] s, e);
    n_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang();
    fails++;
    end_sim();
  endtask
  // one processor read: checks the byte, returns cycles from take to answer
  task automatic fetch(input logic [23:0] a, output int c);
    int i;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_addr = a;
    // ready is combinational: look only once it has settled
    for (i = 0; i < 3000; i++) begin
      #1;
      if (req_ready === 1'b1) break;
      @(negedge core_clk);
    end
    if (i == 3000) hang();
    @(negedge core_clk);
    req_valid = 1'b0;
    for (c = 1; c < 3000 && resp_valid !== 1'b1; c++) @(negedge core_clk);
    if (c == 3000) hang();
    check("fetch data", resp_data, mem(a));
    resp_ready = 1'b1;
    @(negedge core_clk);
    resp_ready = 1'b0;
    check("one byte", resp_valid, 1'b0);
  endtask
  // firmware command: load, launch, poll the self-clearing bit
  task automatic cmd(input logic [63:0] b, input logic [3:0] n);
    int i;
    @(negedge core_clk);
    cmd_buf = b;
    cnt = n;
    launch = 1'b1;
    @(negedge core_clk);
    launch = 1'b0;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge core_clk);
    if (i == 3000) hang();
    check("clocks", 64'(fl.nbits), 64'(n) * 8);
    check("select", cs_n, 1'b1);
  endtask
  task automatic t_single();
    int c, n0, i;
    n0 = n_cs;
    fetch(24'h000100, c);
    check("op", fl.rx_log[0], 8'h0b);
    fetch(24'h000101, c);
    check("burst", 64'(n_cs), 64'(n0 + 1));
    fetch(24'h000200, c);
    check("jump", 64'(n_cs), 64'(n0 + 2));
    check("addr", {fl.rx_log[1], fl.rx_log[2], fl.rx_log[3]}, 24'h200);
    fetch(24'h000201, c);
    fetch(24'h000200, c);
    check("hit time", 64'(c), 64'h1);
    check("no access", 64'(n_cs), 64'(n0 + 2));
    for (i = 0; i < 34; i++) fetch(24'h000300 + 24'(i), c);
    fetch(24'h000302, c);
    check("kept", 64'(c), 64'h1);
    fetch(24'h000300, c);
    check("evicted", 64'(c > 1), 64'h1);
  endtask
  task automatic t_dual();
    int c, i;
    for (i = 0; i < 2; i++) begin
      @(negedge core_clk);
      dual = 1'b1;
      l30 = i[0];
      fetch(24'h000400, c);
      check("mode op", fl.rx_log[0], i ? 8'h3b : 8'h0b);
      check("flushed", 64'(c > 1), 64'h1);
      fetch(24'h000401, c);
    end
  endtask
  task automatic t_cmd();
    logic [7:0] ops [0:2];
    int i;
    ops = '{sfc_pkg::SFC_SECTOR_ERASE_OP, sfc_pkg::SFC_BLOCK32_ERASE_OP,
      sfc_pkg::SFC_BLOCK64_ERASE_OP};
    exec_int = 1'b1; // running from internal memory
    for (i = 0; i < 3; i++) begin
      cmd({40'h0, 24'h452301, ops[i]}, sfc_pkg::SFC_ERASE_LEN);
      check("erase op", fl.rx_log[0], ops[i]);
      check("erase addr", fl.rx_log[3], 8'h45);
    end
    cmd({24'h0, 32'ha5452301, 8'h02}, sfc_pkg::SFC_PROGRAM_LEN);
    check("prog data", fl.rx_log[4], 8'ha5);
    cmd(64'(WEN_OP), sfc_pkg::SFC_OPCODE_LEN);
    check("one op", fl.rx_log[0], WEN_OP);
    cmd(64'h9f, sfc_pkg::SFC_ID_LEN);
    check("id", resp_buf[23:0], {ID[7:0], ID[15:8], ID[23:16]});
    cmd(64'hf1f2f3f4f5f6f7ab, 4'ha);
    check("last buf", fl.rx_log[7], 8'hf1);
    check("fill", {fl.rx_log[8], fl.rx_log[9]}, 16'h0);
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    exec_int = 1'b0; // boot search found code: fetch from flash
    t_single();
    t_dual();
    t_cmd();
    end_sim();
  end
endmodule
